/* rtl/pha_defs.vh */
// Constants for the peripheral adapter host port: register picks,
// flag and control field positions, line modes and shift counts.
// Assumes inclusion by bare name from the design files that use it.
// How it works
// - Reset zeroes registers except timers, shift data
// - Reset leaves every peripheral line an input
// - Reset disables timers, shifter and interrupt request
// - Bus transfers happen only on phase-two clock
// - Direction low: store host byte into picked register
// - Direction high and selected: drive picked register
// - Data lines stay undriven during write cycles
// - Unselected: all eight data lines released
// - Shift-out bit changes after phase-two falling edge
// - Shift-in samples serial line on phase-two rise
// - Read handshake: strobe edge returns handshake high
// - Write handshake: line low after phase-two rise
// - Latching captures port data on strobe edge
// - Selected only when high select high, low select low
// - Four pick inputs choose one of sixteen registers
// - Open-drain request low when enabled flag set
`ifndef PHA_DEFS_VH
`define PHA_DEFS_VH

`define PHA_RST_BYTE     8'h00
`define PHA_RST_WORD     16'h0000
`define PHA_SR_BITS      4'h8
`define PHA_CNT_ONE      4'h1
`define PHA_CNT_ZERO     4'h0

// Register picks
`define PHA_REG_ORB      4'h0
`define PHA_REG_ORA      4'h1
`define PHA_REG_DDRB     4'h2
`define PHA_REG_DDRA     4'h3
`define PHA_REG_T1CL     4'h4
`define PHA_REG_T1CH     4'h5
`define PHA_REG_T1LL     4'h6
`define PHA_REG_T1LH     4'h7
`define PHA_REG_T2CL     4'h8
`define PHA_REG_T2CH     4'h9
`define PHA_REG_SR       4'hA
`define PHA_REG_ACR      4'hB
`define PHA_REG_PCR      4'hC
`define PHA_REG_IFR      4'hD
`define PHA_REG_IER      4'hE
`define PHA_REG_ORA_NH   4'hF

// Interrupt flag bit positions
`define PHA_IF_CA2       0
`define PHA_IF_CA1       1
`define PHA_IF_SR        2
`define PHA_IF_CB2       3
`define PHA_IF_CB1       4
`define PHA_IF_ANY       7
`define PHA_IER_SETBIT   7

// Auxiliary control fields
`define PHA_ACR_LATCH_A  0
`define PHA_ACR_LATCH_B  1
`define PHA_ACR_SR_HI    4
`define PHA_ACR_SR_LO    2
`define PHA_SR_IN_PHI2   3'h2
`define PHA_SR_OUT_PHI2  3'h6

// Peripheral control fields
`define PHA_PCR_CA1_POL  0
`define PHA_PCR_CA2_HI   3
`define PHA_PCR_CA2_LO   1
`define PHA_PCR_CB1_POL  4
`define PHA_PCR_CB2_HI   7
`define PHA_PCR_CB2_LO   5

// Handshake line modes (three-bit field)
`define PHA_CTL_OUT      2
`define PHA_CTL_IN_POL   1
`define PHA_CTL_HSHAKE   3'h4
`define PHA_CTL_PULSE    3'h5
`define PHA_CTL_LOW      3'h6
`define PHA_CTL_HIGH     3'h7

`endif

/* rtl/pha_sync.v */
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes inputs asynchronous to ref_clk_i; only the second stage is used.
`timescale 1ns/1ps
`default_nettype none
module pha_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_i,
  // Pins and synchronised view
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds the second stage only
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule // pha_sync
`default_nettype wire

/* rtl/pha_port.v */
// One 8-bit peripheral port: output and direction registers,
// input latch and the read view of the port.
// Assumes pin_i already synchronised and write strobes single-cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pha_defs.vh"
module pha_port #(
  parameter W           = 8,
  parameter READ_OUTREG = 0
) (
  // Clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_i,
  // Register writes
  input  wire [W-1:0] wdata_i,
  input  wire         wr_out_i,
  input  wire         wr_dir_i,
  // Latching control
  input  wire         latch_en_i,
  input  wire         strobe_edge_i,
  // Pins
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] pin_o,
  output wire [W-1:0] pin_oe_o,
  // Read views
  output wire [W-1:0] rd_in_o,
  output wire [W-1:0] rd_out_o,
  output wire [W-1:0] rd_dir_o
);

  reg  [W-1:0] out_r;
  reg  [W-1:0] dir_r;
  reg  [W-1:0] latch_r;
  wire [W-1:0] in_view;

  // Direction zero after reset keeps every pin undriven
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_r <= {W{1'b0}};
      dir_r <= {W{1'b0}};
    end else begin
      if (wr_out_i)
        out_r <= wdata_i;
      if (wr_dir_i)
        dir_r <= wdata_i;
    end
  end

  // Input latch follows the strobe's active edge
  always @(posedge ref_clk_i) begin
    if (rst_i)
      latch_r <= {W{1'b0}};
    else if (latch_en_i && strobe_edge_i)
      latch_r <= pin_i;
  end

  assign in_view = latch_en_i ? latch_r : pin_i;

  // Output bits may read back the register instead of the loaded pin
  genvar b;
  generate
    for (b = 0; b < W; b = b + 1) begin : g_bit
      if (READ_OUTREG != 0) begin : g_reg
        assign rd_in_o[b] = dir_r[b] ? out_r[b] : in_view[b];
      end else begin : g_pin
        assign rd_in_o[b] = in_view[b];
      end
    end
  endgenerate

  assign pin_o    = out_r;
  assign pin_oe_o = dir_r;
  assign rd_out_o = out_r;
  assign rd_dir_o = dir_r;

endmodule // pha_port
`default_nettype wire

/* rtl/pha_host_port.v */
// Peripheral adapter host side: phase-two bus slave, sixteen registers,
// port handshakes, input latching, phase-two shifting and interrupt line.
// Assumes every pin input is asynchronous; phase-two high phase >= 4 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "pha_defs.vh"
module pha_host_port (
  // Clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_i,
  // Host bus
  input  wire       phi2_i,
  input  wire       select_high_i,
  input  wire       select_low_n_i,
  input  wire       rw_i,
  input  wire [3:0] register_pick_i,
  input  wire [7:0] host_data_i,
  output reg  [7:0] host_data_o,
  output wire       host_data_oe_o,
  // Interrupt request, open drain
  output wire       irq_n_o,
  output wire       irq_n_oe_o,
  // Port A
  input  wire [7:0] port_a_i,
  output wire [7:0] port_a_o,
  output wire [7:0] port_a_oe_o,
  input  wire       port_a_strobe_i,
  input  wire       port_a_handshake_i,
  output reg        port_a_handshake_o,
  output wire       port_a_handshake_oe_o,
  // Port B
  input  wire [7:0] port_b_i,
  output wire [7:0] port_b_o,
  output wire [7:0] port_b_oe_o,
  input  wire       port_b_strobe_i,
  input  wire       port_b_serial_i,
  output wire       port_b_serial_o,
  output wire       port_b_serial_oe_o
);

  // Synchronised pins
  wire [35:0] pins_q;
  wire        phi2_q;
  wire        sel_hi_q;
  wire        sel_lo_n_q;
  wire        rw_q;
  wire [3:0]  pick_q;
  wire [7:0]  data_q;
  wire [7:0]  pa_q;
  wire [7:0]  pb_q;
  wire        ca1_q;
  wire        ca2_q;
  wire        cb1_q;
  wire        cb2_q;

  pha_sync #(
    .W (36)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({phi2_i, select_high_i, select_low_n_i, rw_i, register_pick_i,
                 host_data_i, port_a_i, port_b_i, port_a_strobe_i,
                 port_a_handshake_i, port_b_strobe_i, port_b_serial_i}),
    .q_o       (pins_q)
  );

  assign {phi2_q, sel_hi_q, sel_lo_n_q, rw_q, pick_q, data_q, pa_q, pb_q,
          ca1_q, ca2_q, cb1_q, cb2_q} = pins_q;

  // Edge history, taken from the synchronised copies only
  reg phi2_d;
  reg ca1_d;
  reg ca2_d;
  reg cb1_d;
  reg cb2_d;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      phi2_d <= 1'b0;
      ca1_d  <= 1'b0;
      ca2_d  <= 1'b0;
      cb1_d  <= 1'b0;
      cb2_d  <= 1'b0;
    end else begin
      phi2_d <= phi2_q;
      ca1_d  <= ca1_q;
      ca2_d  <= ca2_q;
      cb1_d  <= cb1_q;
      cb2_d  <= cb2_q;
    end
  end

  // Control registers
  reg [7:0]  acr_r;
  reg [7:0]  pcr_r;
  reg [6:0]  ier_r;
  reg [6:0]  ifr_r;
  // Timer storage and shift data keep contents through reset
  reg [15:0] t1_latch_r;
  reg [15:0] t1_cnt_r;
  reg [7:0]  t2_latch_lo_r;
  reg [15:0] t2_cnt_r;
  reg [7:0]  sr_r;
  reg [3:0]  sr_cnt_r;
  reg        sr_bit_r;
  reg        ca2_pulse_r;
  reg        a_wr_pend_r;
  reg        cb2_line_r;
  reg        cb2_pulse_r;
  reg        b_wr_pend_r;

  wire phi2_rise = phi2_q & ~phi2_d;
  wire phi2_fall = ~phi2_q & phi2_d;
  wire selected  = sel_hi_q & ~sel_lo_n_q;
  // A transfer completes only on the falling phase-two edge
  wire acc     = phi2_fall & selected;
  wire wr_acc  = acc & ~rw_q;
  wire rd_acc  = acc & rw_q;
  wire [2:0] ca2_mode = pcr_r[`PHA_PCR_CA2_HI:`PHA_PCR_CA2_LO];
  wire [2:0] cb2_mode = pcr_r[`PHA_PCR_CB2_HI:`PHA_PCR_CB2_LO];
  wire [2:0] sr_mode  = acr_r[`PHA_ACR_SR_HI:`PHA_ACR_SR_LO];
  wire sr_in    = (sr_mode == `PHA_SR_IN_PHI2);
  wire sr_out   = (sr_mode == `PHA_SR_OUT_PHI2);
  wire sr_busy  = (sr_cnt_r != `PHA_CNT_ZERO);

  // Active edges of the handshake and strobe lines
  wire ca1_edge = pcr_r[`PHA_PCR_CA1_POL] ? (ca1_q & ~ca1_d) : (~ca1_q & ca1_d);
  wire cb1_edge = pcr_r[`PHA_PCR_CB1_POL] ? (cb1_q & ~cb1_d) : (~cb1_q & cb1_d);
  wire ca2_edge = ca2_mode[`PHA_CTL_IN_POL] ? (ca2_q & ~ca2_d) : (~ca2_q & ca2_d);
  wire cb2_edge = cb2_mode[`PHA_CTL_IN_POL] ? (cb2_q & ~cb2_d) : (~cb2_q & cb2_d);
  wire ca2_in   = ~ca2_mode[`PHA_CTL_OUT];
  wire cb2_in   = ~cb2_mode[`PHA_CTL_OUT] & ~sr_out & ~sr_in;

  // Accesses that carry side effects
  wire acc_a   = acc & (pick_q == `PHA_REG_ORA);
  wire acc_b   = acc & (pick_q == `PHA_REG_ORB);
  wire acc_sr  = acc & (pick_q == `PHA_REG_SR);
  wire wr_a    = wr_acc & ((pick_q == `PHA_REG_ORA) | (pick_q == `PHA_REG_ORA_NH));
  wire wr_b    = wr_acc & (pick_q == `PHA_REG_ORB);
  wire wr_da   = wr_acc & (pick_q == `PHA_REG_DDRA);
  wire wr_db   = wr_acc & (pick_q == `PHA_REG_DDRB);
  wire sr_step_in  = sr_in & sr_busy & phi2_rise;
  wire sr_step_out = sr_out & sr_busy & phi2_fall & ~acc_sr;
  wire sr_done = (sr_step_in | sr_step_out) & (sr_cnt_r == `PHA_CNT_ONE);

  // Ports
  wire [7:0] pa_in_v;
  wire [7:0] pa_out_v;
  wire [7:0] pa_dir_v;
  wire [7:0] pb_in_v;
  wire [7:0] pb_out_v;
  wire [7:0] pb_dir_v;

  pha_port #(
    .W           (8),
    .READ_OUTREG (0)
  ) u_port_a (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .wdata_i       (data_q),
    .wr_out_i      (wr_a),
    .wr_dir_i      (wr_da),
    .latch_en_i    (acr_r[`PHA_ACR_LATCH_A]),
    .strobe_edge_i (ca1_edge),
    .pin_i         (pa_q),
    .pin_o         (port_a_o),
    .pin_oe_o      (port_a_oe_o),
    .rd_in_o       (pa_in_v),
    .rd_out_o      (pa_out_v),
    .rd_dir_o      (pa_dir_v)
  );

  pha_port #(
    .W           (8),
    .READ_OUTREG (1)
  ) u_port_b (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .wdata_i       (data_q),
    .wr_out_i      (wr_b),
    .wr_dir_i      (wr_db),
    .latch_en_i    (acr_r[`PHA_ACR_LATCH_B]),
    .strobe_edge_i (cb1_edge),
    .pin_i         (pb_q),
    .pin_o         (port_b_o),
    .pin_oe_o      (port_b_oe_o),
    .rd_in_o       (pb_in_v),
    .rd_out_o      (pb_out_v),
    .rd_dir_o      (pb_dir_v)
  );

  // Control register writes; zero after reset disables timers and shifter
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      acr_r <= `PHA_RST_BYTE;
      pcr_r <= `PHA_RST_BYTE;
      ier_r <= 7'h00;
    end else if (wr_acc) begin
      case (pick_q)
        `PHA_REG_ACR: acr_r <= data_q;
        `PHA_REG_PCR: pcr_r <= data_q;
        `PHA_REG_IER: begin
          // Top bit picks set or clear of the ones written
          if (data_q[`PHA_IER_SETBIT])
            ier_r <= ier_r | data_q[6:0];
          else
            ier_r <= ier_r & ~data_q[6:0];
        end
        default: ier_r <= ier_r;
      endcase
    end
  end

  // Timer storage: no reset term, contents survive reset
  always @(posedge ref_clk_i) begin
    if (wr_acc) begin
      case (pick_q)
        `PHA_REG_T1CL, `PHA_REG_T1LL: t1_latch_r[7:0] <= data_q;
        `PHA_REG_T1LH: t1_latch_r[15:8] <= data_q;
        `PHA_REG_T1CH: begin
          t1_latch_r[15:8] <= data_q;
          t1_cnt_r         <= {data_q, t1_latch_r[7:0]};
        end
        `PHA_REG_T2CL: t2_latch_lo_r <= data_q;
        `PHA_REG_T2CH: t2_cnt_r <= {data_q, t2_latch_lo_r};
        default: t2_cnt_r <= t2_cnt_r;
      endcase
    end
  end

  // Shift data: host write wins over a shift step in the same cycle
  always @(posedge ref_clk_i) begin
    if (wr_acc && (pick_q == `PHA_REG_SR))
      sr_r <= data_q;
    else if (sr_step_in)
      sr_r <= {sr_r[6:0], cb2_q};
    else if (sr_step_out)
      sr_r <= {sr_r[6:0], sr_r[7]};
  end

  // Shift counter and the bit shown on the serial line
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sr_cnt_r <= `PHA_CNT_ZERO;
      sr_bit_r <= 1'b0;
    end else begin
      if (acc_sr && (sr_in || sr_out))
        sr_cnt_r <= `PHA_SR_BITS;
      else if (sr_step_in || sr_step_out)
        sr_cnt_r <= sr_cnt_r - `PHA_CNT_ONE;
      if (sr_step_out)
        sr_bit_r <= sr_r[7];
    end
  end

  // Flags: hardware set wins over clear by write or port access
  reg [6:0] ifr_set;
  reg [6:0] ifr_clr;

  always @* begin
    ifr_set = 7'h00;
    ifr_clr = 7'h00;
    ifr_set[`PHA_IF_CA1] = ca1_edge;
    ifr_set[`PHA_IF_CA2] = ca2_edge & ca2_in;
    ifr_set[`PHA_IF_CB1] = cb1_edge;
    ifr_set[`PHA_IF_CB2] = cb2_edge & cb2_in;
    ifr_set[`PHA_IF_SR]  = sr_done;
    if (wr_acc && (pick_q == `PHA_REG_IFR))
      ifr_clr = data_q[6:0];
    if (acc_a) begin
      ifr_clr[`PHA_IF_CA1] = 1'b1;
      ifr_clr[`PHA_IF_CA2] = 1'b1;
    end
    if (acc_b) begin
      ifr_clr[`PHA_IF_CB1] = 1'b1;
      ifr_clr[`PHA_IF_CB2] = 1'b1;
    end
    if (acc_sr)
      ifr_clr[`PHA_IF_SR] = 1'b1;
  end

  always @(posedge ref_clk_i) begin
    if (rst_i)
      ifr_r <= 7'h00;
    else
      ifr_r <= (ifr_r & ~ifr_clr) | ifr_set;
  end

  wire irq_any = |(ifr_r & ier_r);
  assign irq_n_o    = 1'b0;
  assign irq_n_oe_o = irq_any;

  // Port A handshake line: read goes low at once, write after next rise
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_a_handshake_o <= 1'b1;
      ca2_pulse_r        <= 1'b0;
      a_wr_pend_r        <= 1'b0;
    end else begin
      ca2_pulse_r <= 1'b0;
      case (ca2_mode)
        `PHA_CTL_HSHAKE, `PHA_CTL_PULSE: begin
          if (acc_a && rw_q)
            port_a_handshake_o <= 1'b0;
          else if (a_wr_pend_r && phi2_rise)
            port_a_handshake_o <= 1'b0;
          else if (ca2_mode == `PHA_CTL_HSHAKE && ca1_edge)
            port_a_handshake_o <= 1'b1;
          else if (ca2_mode == `PHA_CTL_PULSE && ca2_pulse_r)
            port_a_handshake_o <= 1'b1;
          // Pulse mode ends after the next phase-two fall
          if (ca2_mode == `PHA_CTL_PULSE && !port_a_handshake_o && phi2_fall)
            ca2_pulse_r <= 1'b1;
        end
        `PHA_CTL_LOW:  port_a_handshake_o <= 1'b0;
        `PHA_CTL_HIGH: port_a_handshake_o <= 1'b1;
        default:       port_a_handshake_o <= 1'b1;
      endcase
      if (acc_a && !rw_q)
        a_wr_pend_r <= 1'b1;
      else if (phi2_rise)
        a_wr_pend_r <= 1'b0;
    end
  end

  assign port_a_handshake_oe_o = ~ca2_in;

  // Port B handshake line: write handshake only
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cb2_line_r  <= 1'b1;
      cb2_pulse_r <= 1'b0;
      b_wr_pend_r <= 1'b0;
    end else begin
      cb2_pulse_r <= 1'b0;
      case (cb2_mode)
        `PHA_CTL_HSHAKE, `PHA_CTL_PULSE: begin
          if (b_wr_pend_r && phi2_rise)
            cb2_line_r <= 1'b0;
          else if (cb2_mode == `PHA_CTL_HSHAKE && cb1_edge)
            cb2_line_r <= 1'b1;
          else if (cb2_mode == `PHA_CTL_PULSE && cb2_pulse_r)
            cb2_line_r <= 1'b1;
          if (cb2_mode == `PHA_CTL_PULSE && !cb2_line_r && phi2_rise)
            cb2_pulse_r <= 1'b1;
        end
        `PHA_CTL_LOW:  cb2_line_r <= 1'b0;
        `PHA_CTL_HIGH: cb2_line_r <= 1'b1;
        default:       cb2_line_r <= 1'b1;
      endcase
      if (wr_b)
        b_wr_pend_r <= 1'b1;
      else if (phi2_rise)
        b_wr_pend_r <= 1'b0;
    end
  end

  // Shifter owns the serial line in shift-out mode
  assign port_b_serial_o    = sr_out ? sr_bit_r : cb2_line_r;
  assign port_b_serial_oe_o = sr_out | (~sr_in & cb2_mode[`PHA_CTL_OUT]);

  // Read data register, refreshed every clock from the picked register
  reg [7:0] rd_mux;

  always @* begin
    case (pick_q)
      `PHA_REG_ORB:    rd_mux = pb_in_v;
      `PHA_REG_ORA:    rd_mux = pa_in_v;
      `PHA_REG_ORA_NH: rd_mux = pa_in_v;
      `PHA_REG_DDRB:   rd_mux = pb_dir_v;
      `PHA_REG_DDRA:   rd_mux = pa_dir_v;
      `PHA_REG_T1CL:   rd_mux = t1_cnt_r[7:0];
      `PHA_REG_T1CH:   rd_mux = t1_cnt_r[15:8];
      `PHA_REG_T1LL:   rd_mux = t1_latch_r[7:0];
      `PHA_REG_T1LH:   rd_mux = t1_latch_r[15:8];
      `PHA_REG_T2CL:   rd_mux = t2_cnt_r[7:0];
      `PHA_REG_T2CH:   rd_mux = t2_cnt_r[15:8];
      `PHA_REG_SR:     rd_mux = sr_r;
      `PHA_REG_ACR:    rd_mux = acr_r;
      `PHA_REG_PCR:    rd_mux = pcr_r;
      `PHA_REG_IFR:    rd_mux = {irq_any, ifr_r};
      `PHA_REG_IER:    rd_mux = {1'b1, ier_r};
      default:         rd_mux = `PHA_RST_BYTE;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (rst_i)
      host_data_o <= `PHA_RST_BYTE;
    else
      host_data_o <= rd_mux;
  end

  // Drive only while selected, reading, and phase two high
  assign host_data_oe_o = selected & rw_q & phi2_q;

  // Unused read views kept for port A and port B output registers
  wire unused_ok = &{1'b0, pa_out_v, pb_out_v};

endmodule // pha_host_port
`default_nettype wire

/* verification/pha_host_port_asserts.sv */
// Checker for the host port: data pin drive, reset state, interrupt line.
// Assumes a bind onto pha_host_port; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pha_host_port_asserts (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // Host bus
  input wire logic       phi2_i,
  input wire logic       select_high_i,
  input wire logic       select_low_n_i,
  input wire logic       rw_i,
  input wire logic       host_data_oe_o,
  // Interrupt and peripheral side
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe_o,
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_o,
  input wire logic [7:0] port_b_oe_o,
  input wire logic       port_a_handshake_o,
  input wire logic       port_a_handshake_oe_o,
  input wire logic       port_b_serial_oe_o
);
  logic rst_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Reset echo; the first cycles after release still show reset updates
  always_ff @(posedge ref_clk_i) rst_q <= rst_i;
  property p_rst;
    disable iff (1'b0) rst_i |=> !host_data_oe_o && !irq_n_oe_o && port_a_o == 8'h00 && port_b_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rst_pins;
    disable iff (1'b0) rst_i |=> port_a_oe_o == 8'h00 && port_b_oe_o == 8'h00 && !port_a_handshake_oe_o
      && !port_b_serial_oe_o && port_a_handshake_o;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("peripheral line driven after reset");
  property p_rd;
    (phi2_i && select_high_i && !select_low_n_i && rw_i)[*4] |-> host_data_oe_o;
  endproperty
  a_rd: assert property (p_rd) else $error("selected read not driven");
  property p_wr;
    (!rw_i)[*3] |-> !host_data_oe_o;
  endproperty
  a_wr: assert property (p_wr) else $error("data pins driven in write");
  property p_unsel_hi;
    (!select_high_i)[*3] |-> !host_data_oe_o;
  endproperty
  a_unsel_hi: assert property (p_unsel_hi) else $error("driven with high select low");
  property p_unsel_lo;
    select_low_n_i[*3] |-> !host_data_oe_o;
  endproperty
  a_unsel_lo: assert property (p_unsel_lo) else $error("driven with low select high");
  property p_phi2;
    (!phi2_i)[*3] |-> !host_data_oe_o;
  endproperty
  a_phi2: assert property (p_phi2) else $error("driven outside phase two");
  property p_irq;
    irq_n_oe_o |-> !irq_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("request line not pulled low");
  property p_quiet;
    ($stable(phi2_i) && !rst_q)[*6] |-> $stable(port_a_o) && $stable(port_a_oe_o) && $stable(port_b_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("register changed without phase two");
  c_read: cover property (host_data_oe_o);
  c_irq: cover property (irq_n_oe_o);
  c_hs: cover property (port_a_handshake_oe_o && !port_a_handshake_o);
endmodule // pha_host_port_asserts
bind pha_host_port pha_host_port_asserts u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .phi2_i(phi2_i), .select_high_i(select_high_i),
  .select_low_n_i(select_low_n_i), .rw_i(rw_i), .host_data_oe_o(host_data_oe_o), .irq_n_o(irq_n_o),
  .irq_n_oe_o(irq_n_oe_o), .port_a_o(port_a_o), .port_a_oe_o(port_a_oe_o), .port_b_o(port_b_o),
  .port_b_oe_o(port_b_oe_o), .port_a_handshake_o(port_a_handshake_o),
  .port_a_handshake_oe_o(port_a_handshake_oe_o), .port_b_serial_oe_o(port_b_serial_oe_o));
`default_nettype wire

/* verification/pha_cpu_model.sv */
// Processor bus model: makes phase two and runs one access per cycle.
// Assumes the device drive of the data pins is fed back to resolve them.
`timescale 1ns/1ps
`default_nettype none
module pha_cpu_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Device drive of the data pins
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  // Bus pins
  output logic            phi2_o,
  output logic            sel_hi_o,
  output logic            sel_lo_n_o,
  output logic            rw_o,
  output logic [3:0]      pick_o,
  output wire logic [7:0] bus_o
);
  logic [7:0] wdata_r;
  logic       drv_r;
  logic [7:0] last_r;
  // Released pins show the inverse of the last level, never a stale copy
  assign bus_o = dev_oe_i ? dev_data_i : (drv_r ? wdata_r : ~last_r);
  always @(posedge ref_clk_i) last_r <= bus_o;
  // Idle bus at time zero
  initial begin
    {phi2_o, sel_hi_o, drv_r} = 3'h0;
    {sel_lo_n_o, rw_o} = 2'h3;
    pick_o = 4'h0;
    wdata_r = 8'h00;
    last_r = 8'h00;
  end
  // Pins settle in phase one and hold past the phase-two fall
  task automatic access(input logic hi, input logic lo_n, input logic rw, input logic [3:0] pick,
                        input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 {sel_hi_o, sel_lo_n_o, rw_o, pick_o} = {hi, lo_n, rw, pick};
    wdata_r = d;
    drv_r = !rw;
    repeat (4) @(posedge ref_clk_i);
    #1 phi2_o = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1 phi2_o = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 {drv_r, sel_hi_o, sel_lo_n_o, rw_o} = 4'h3;
  endtask
endmodule // pha_cpu_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the host port with a processor model in front.
// Assumes port pins resolve here from device drive and bench values.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_i, sa, sb, ser, phi2_q;
  logic [7:0] pa_drv, pb_drv, v, w, host_data_o, pa_o, pa_oe, pb_o, pb_oe;
  logic host_data_oe_o, irq_n_o, irq_n_oe_o, ha_o, ha_oe, ser_o, ser_oe;
  logic phi2, s_hi, s_lo_n, rw;
  logic [3:0] pick;
  wire  [7:0] bus;
  logic [15:0] expq [$];
  logic [15:0] e;
  logic [3:0] rst_picks [6] = '{4'h2, 4'h3, 4'hB, 4'hC, 4'hD, 4'hE};
  logic [3:0] rw_picks [4] = '{4'h2, 4'h3, 4'h6, 4'h7};
  int failures = 0, checks_done = 0, seed = 32'hfacaa44c;
  // Pin levels from every driver of each line
  wire [7:0] pa_w = (pa_oe & pa_o) | (~pa_oe & pa_drv);
  wire [7:0] pb_w = (pb_oe & pb_o) | (~pb_oe & pb_drv);
  wire       ha_w = ha_oe ? ha_o : 1'b1;
  wire       sb_w = ser_oe ? ser_o : ser;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  pha_cpu_model cpu (.ref_clk_i(clk), .dev_data_i(host_data_o), .dev_oe_i(host_data_oe_o), .phi2_o(phi2),
    .sel_hi_o(s_hi), .sel_lo_n_o(s_lo_n), .rw_o(rw), .pick_o(pick), .bus_o(bus));
  pha_host_port DUT (.ref_clk_i(clk), .rst_i(rst_i), .phi2_i(phi2), .select_high_i(s_hi), .select_low_n_i(s_lo_n),
    .rw_i(rw), .register_pick_i(pick), .host_data_i(bus), .host_data_o(host_data_o),
    .host_data_oe_o(host_data_oe_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o), .port_a_i(pa_w),
    .port_a_o(pa_o), .port_a_oe_o(pa_oe), .port_a_strobe_i(sa), .port_a_handshake_i(ha_w),
    .port_a_handshake_o(ha_o), .port_a_handshake_oe_o(ha_oe), .port_b_i(pb_w), .port_b_o(pb_o),
    .port_b_oe_o(pb_oe), .port_b_strobe_i(sb), .port_b_serial_i(sb_w), .port_b_serial_o(ser_o),
    .port_b_serial_oe_o(ser_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    cpu.access(1'b1, 1'b0, 1'b0, p, d);
  endtask
  // Expected value noted before the read; the monitor compares it
  task automatic rd(input logic [3:0] p, input logic [7:0] x, input logic [7:0] m);
    expq.push_back({m, x});
    cpu.access(1'b1, 1'b0, 1'b1, p, 8'h00);
  endtask
  task automatic idle();
    cpu.access(1'b0, 1'b1, 1'b1, 4'h0, 8'h00);
  endtask
  // Read data taken where phase two is seen falling
  always @(posedge clk) begin
    if (phi2_q === 1'b1 && phi2 === 1'b0 && host_data_oe_o === 1'b1) begin
      if (expq.size() == 0) begin
        check(8'h00, 8'h01);
      end else begin
        e = expq.pop_front();
        check(host_data_o & e[15:8], e[7:0] & e[15:8]);
      end
    end
    phi2_q <= phi2;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    check(8'h00, 8'h01);
    test_done();
  end
  initial begin
    {rst_i, ser} = 2'h3;
    {sa, sb} = 2'h0;
    {pa_drv, pb_drv} = 16'h0000;
    repeat (6) @(posedge clk);
    #1 rst_i = 1'b0;
    repeat (3) @(posedge clk);
    #1 pa_drv = $random(seed);
    pb_drv = $random(seed);
    // Controls clear, enable reads bit seven set, ports read pins
    for (int i = 0; i < 6; i++) rd(rst_picks[i], (i == 5) ? 8'h80 : 8'h00, 8'hFF);
    rd(4'hF, pa_drv, 8'hFF);
    rd(4'h0, pb_drv, 8'hFF);
    // Mis-selected accesses store nothing and drive nothing
    for (int i = 0; i < 3; i++) begin
      cpu.access(i == 1, i != 0, 1'b0, 4'h3, 8'hFF);
      cpu.access(i == 1, i != 0, 1'b1, 4'h3, 8'h00);
    end
    rd(4'h3, 8'h00, 8'hFF);
    check(pa_oe, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(rw_picks[i], v);
      rd(rw_picks[i], v, 8'hFF);
    end
    v = $random(seed);
    w = $random(seed);
    wr(4'h2, v);
    wr(4'h0, w);
    check(pb_oe, v);
    check(pb_o, w);
    rd(4'h0, (v & w) | (~v & pb_drv), 8'hFF);
    wr(4'h1, w);
    check(pa_o, w);
    // Enable register set and clear
    wr(4'hE, 8'h9F);
    rd(4'hE, 8'h9F, 8'hFF);
    wr(4'hE, 8'h0C);
    rd(4'hE, 8'h93, 8'hFF);
    wr(4'hE, 8'h7F);
    wr(4'hE, 8'h82);
    // Read handshake and latching on port A
    wr(4'h3, 8'h00);
    wr(4'hC, 8'h09);
    wr(4'hB, 8'h01);
    v = $random(seed);
    pa_drv = v;
    #1 sa = 1'b1;
    repeat (6) @(posedge clk);
    check(irq_n_oe_o, 8'h01);
    pa_drv = ~v;
    rd(4'h1, v, 8'hFF);
    check(ha_o, 8'h00);
    check(ha_oe, 8'h01);
    check(irq_n_oe_o, 8'h00);
    sa = 1'b0;
    repeat (4) @(posedge clk);
    #1 sa = 1'b1;
    repeat (6) @(posedge clk);
    check(ha_o, 8'h01);
    // Write handshake on port B
    wr(4'hC, 8'h90);
    v = $random(seed);
    wr(4'h0, v);
    idle();
    check(ser_o, 8'h00);
    check(pb_o, v);
    #1 sb = 1'b1;
    repeat (6) @(posedge clk);
    check(ser_o, 8'h01);
    // Shift in, eight phase-two rises
    wr(4'hC, 8'h00);
    wr(4'hD, 8'h7F);
    wr(4'hB, 8'h08);
    wr(4'hA, 8'h00);
    v = $random(seed);
    for (int i = 7; i >= 0; i--) begin
      ser = v[i];
      idle();
    end
    rd(4'hD, 8'h04, 8'h04);
    rd(4'hA, v, 8'hFF);
    // Shift out, one bit per phase-two fall
    wr(4'hB, 8'h18);
    v = $random(seed);
    wr(4'hA, v);
    for (int i = 7; i >= 0; i--) begin
      idle();
      repeat (3) @(posedge clk);
      check(ser_o, v[i]);
    end
    check(ser_oe, 8'h01);
    repeat (4) @(posedge clk);
    check(expq.size(), 8'h00);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
